// >>> src/epd_pkg.sv
package epd_pkg;
    // ****************************************
    // group geometry
    // ****************************************
    localparam int          EPD_SLOTS      = 8;     // words per fetch group
    localparam int          EPD_WORD_W     = 32;    // instruction width
    localparam int          EPD_SLOT_IDX_W = 3;     // slot index width
    localparam int          EPD_CHAIN_BIT  = 0;     // parallel chain bit position
    localparam int          EPD_SLOT_LSB   = 2;     // byte addr bit of slot index
    localparam int          EPD_SLOT_MSB   = 4;     // top byte addr bit of slot index
    localparam int          EPD_ADDR_W     = 32;    // byte address width
    localparam logic [7:0]  EPD_MASK_NONE  = 8'h00; // empty slot mask
    localparam logic [31:0] EPD_WORD_ZERO  = 32'h0000_0000; // idle word value
endpackage : epd_pkg

// >>> src/epd_group_split.sv
`timescale 1ns/10ps
// combinational: from a pending slot mask, pick the next issue group
module epd_group_split
    import epd_pkg::*;
(
    input  wire logic [EPD_SLOTS-1:0] pending_i, // slots still to issue
    input  wire logic [EPD_SLOTS-1:0] chain_i,   // chain bit of each slot
    output logic      [EPD_SLOTS-1:0] group_o,   // slots issued this cycle
    output logic      [EPD_SLOTS-1:0] rest_o     // slots left afterwards
);
    // ****************************************
    // ascending scan
    // ****************************************
    // scan low to high: start at first pending slot, extend while chain is 1
    always_comb begin
        logic started;
        logic open;
        started = 1'b0;
        open    = 1'b0;
        group_o = EPD_MASK_NONE;
        for (int k = 0; k < EPD_SLOTS; k++) begin
            if (!started && pending_i[k]) begin
                started    = 1'b1;
                open       = 1'b1;
                group_o[k] = 1'b1;
            end else if (open && pending_i[k]) begin
                group_o[k] = 1'b1;
            end else begin
                open = 1'b0;
            end
            // a zero chain bit closes the group here
            if (open && !chain_i[k]) begin
                open = 1'b0;
            end
        end
        // the loop ends at slot 7, so a group never runs into the next fetch
        rest_o = pending_i & ~group_o;
    end
endmodule // epd_group_split

// >>> src/epd_dispatch.sv
`timescale 1ns/10ps
// ****************************************
// ****************************************
module epd_dispatch
    import epd_pkg::*;
(
    input  wire logic                            clk_i,       // 200 MHz core clock
    input  wire logic                            reset_n_i,   // async core reset, low
    input  wire logic                            fetch_vld_i, // fetch group offered
    input  wire logic [EPD_ADDR_W-1:0]           fetch_adr_i, // byte address (entry/target)
    input  wire logic [EPD_SLOTS*EPD_WORD_W-1:0] fetch_dat_i, // eight words, slot 0 low
    output logic                                 fetch_rdy_o, // ready for a new group
    output logic                                 issue_vld_o, // issue group valid
    output logic      [EPD_SLOTS-1:0]            issue_msk_o, // slots issued this cycle
    output logic      [EPD_SLOTS*EPD_WORD_W-1:0] issue_dat_o, // words, unissued zeroed
    output logic                                 issue_lst_o, // last group of fetch
    output logic                                 align_err_o  // misaligned group seen
);
    // ****************************************
    // reset release
    // ****************************************
    logic       rst_q1; // first release stage
    logic       rst_n;  // released reset used inside

    // two flops so release is clean against clk_i
    // the rest of the block resets on rst_n, so its release lands on an edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // ****************************************
    // state
    // ****************************************
    // one-hot codes: a stray code falls to the default branch
    typedef enum logic [1:0] {
        EPD_IDLE  = 2'b01, // waiting for a fetch group
        EPD_ISSUE = 2'b10  // splitting the held group
    } epd_state_e;

    epd_state_e                       state;      // current phase
    logic [EPD_SLOTS*EPD_WORD_W-1:0]  words;      // held fetch group
    logic [EPD_SLOTS-1:0]             pending;    // slots not yet issued
    logic [EPD_SLOTS-1:0]             chain;      // chain bits of held group
    logic [EPD_SLOTS-1:0]             entry_msk;  // slots at or above entry
    logic [EPD_SLOTS-1:0]             src_pend;   // mask fed to the splitter
    logic [EPD_SLOTS-1:0]             src_chain;  // chain fed to the splitter
    logic [EPD_SLOTS-1:0]             grp;        // group chosen this cycle
    logic [EPD_SLOTS-1:0]             rest;       // slots left after it
    logic [EPD_SLOTS*EPD_WORD_W-1:0]  src_words;  // words fed to issue
    logic [EPD_SLOTS*EPD_WORD_W-1:0]  next_dat;   // masked issue words
    logic [EPD_SLOT_IDX_W-1:0]        entry_slot; // slot of fetch address
    logic                             take;       // new group accepted
    logic                             busy;       // a group is being issued
    logic [EPD_SLOTS-1:0]             in_chain;   // chain bits of incoming

    // slot index from byte address bits 4:2
    assign entry_slot = fetch_adr_i[EPD_SLOT_MSB:EPD_SLOT_LSB];
    // issuing from the held copy
    assign busy       = (state == EPD_ISSUE);
    // only whole eight-word groups are accepted, one per handshake
    assign take       = fetch_vld_i && fetch_rdy_o;

    // ****************************************
    // per-slot decode
    // ****************************************
    // one copy per slot keeps the eight lanes identical
    genvar gi;
    generate
        for (gi = 0; gi < EPD_SLOTS; gi++) begin : g_slot
            // chain bit is bit 0 of each word
            assign in_chain[gi]  = fetch_dat_i[gi*EPD_WORD_W + EPD_CHAIN_BIT];
            // slots below a branch target are dropped
            assign entry_msk[gi] = (EPD_SLOT_IDX_W'(gi) >= entry_slot);
            // unissued slots go out as zero so no unit sees a stale word
            assign next_dat[gi*EPD_WORD_W +: EPD_WORD_W] =
                grp[gi] ? src_words[gi*EPD_WORD_W +: EPD_WORD_W] : EPD_WORD_ZERO;
        end
    endgenerate

    // new group: pending is rebuilt from entry only, old chain ignored
    // while draining, the held copy feeds the splitter; the bus may hold the next group
    assign src_pend  = busy ? pending : entry_msk;
    assign src_chain = busy ? chain   : in_chain;
    assign src_words = busy ? words   : fetch_dat_i;

    // ****************************************
    // group splitter
    // ****************************************
    // one combinational scan serves the accept cycle and every drain cycle
    epd_group_split u_split (
        .pending_i (src_pend),
        .chain_i   (src_chain),
        .group_o   (grp),
        .rest_o    (rest)
    );

    // ****************************************
    // hold the fetch group
    // ****************************************
    // phase: first group issues in the accept cycle, the rest one a cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= EPD_IDLE;
        end else begin
            case (state)
                EPD_IDLE: begin                                  // nothing held
                    // more slots left: keep issuing one group a cycle
                    if (take && (rest != EPD_MASK_NONE)) begin
                        state <= EPD_ISSUE;
                    end
                end
                EPD_ISSUE: begin                                 // draining held group
                    // last group chosen: free for the next fetch
                    if (rest == EPD_MASK_NONE) begin
                        state <= EPD_IDLE;
                    end
                end
                default: begin                                   // illegal code
                    state <= EPD_IDLE;
                end
            endcase
        end
    end

    // words and chain bits are captured once, at the accept edge;
    // the source may change the bus as soon as it sees the take
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            words <= '0;
            chain <= EPD_MASK_NONE;
        end else if (take) begin                                 // new group accepted
            words <= fetch_dat_i;
            chain <= in_chain;
        end
    end

    // slots still owed: what the splitter left, only while a group is live
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pending <= EPD_MASK_NONE;
        end else if (take || busy) begin                         // a group was chosen
            pending <= rest;
        end
    end

    // ****************************************
    // fetch handshake
    // ****************************************
    // ready only when the last group is going out or nothing is held;
    // registered, but raised in the last drain cycle, so no bubble cycle follows a multi-group fetch
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fetch_rdy_o <= 1'b0;
        end else if (take) begin
            // accepted: stay ready only if it was a single group
            fetch_rdy_o <= (rest == EPD_MASK_NONE);
        end else if (busy) begin
            // draining: ready again as the last group goes out
            fetch_rdy_o <= (rest == EPD_MASK_NONE);
        end else begin
            // idle and nothing held
            fetch_rdy_o <= 1'b1;
        end
    end

    // ****************************************
    // issue outputs
    // ****************************************
    // one group per cycle, one to eight slots, registered
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            issue_vld_o <= 1'b0;
            issue_msk_o <= EPD_MASK_NONE;
            issue_dat_o <= '0;
            issue_lst_o <= 1'b0;
        end else if (take || busy) begin
            // a group is chosen in every accept and drain cycle
            issue_vld_o <= (grp != EPD_MASK_NONE);
            issue_msk_o <= grp;
            issue_dat_o <= next_dat;
            issue_lst_o <= (rest == EPD_MASK_NONE);
        end else begin
            // no group: all quiet, so no unit acts twice on one word
            issue_vld_o <= 1'b0;
            issue_msk_o <= EPD_MASK_NONE;
            issue_dat_o <= '0;
            issue_lst_o <= 1'b0;
        end
    end

    // ****************************************
    // alignment check
    // ****************************************
    // sticky flag: a group with nonzero bits 1:0 means a broken fetch
    // only bits 1:0 are judged; bits 4:2 are the entry slot, not an error
    // set-only until reset, so no set/clear collision can arise
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            align_err_o <= 1'b0;
        end else if (take && (fetch_adr_i[EPD_SLOT_LSB-1:0] != 2'b00)) begin
            align_err_o <= 1'b1;
        end
    end
endmodule // epd_dispatch

// >>> testbench/epd_dispatch_props.sv
`timescale 1ns/10ps
// ****************************************
// dispatch port checks
// ****************************************
module epd_dispatch_props
    import epd_pkg::*;
(
    input wire logic                            clk_i,       // core clock
    input wire logic                            reset_n_i,   // async reset, low
    input wire logic                            fetch_vld_i, // group offered
    input wire logic [EPD_ADDR_W-1:0]           fetch_adr_i, // entry address
    input wire logic [EPD_SLOTS*EPD_WORD_W-1:0] fetch_dat_i, // group words
    input wire logic                            fetch_rdy_o, // ready
    input wire logic                            issue_vld_o, // group valid
    input wire logic [EPD_SLOTS-1:0]            issue_msk_o, // group slots
    input wire logic [EPD_SLOTS*EPD_WORD_W-1:0] issue_dat_o, // group words
    input wire logic                            issue_lst_o, // last group
    input wire logic                            align_err_o  // sticky misalign
);
    logic [7:0]   chn;  // chain bits seen on issue words
    logic [255:0] keep; // mask widened to words
    logic [7:0]   low;  // lowest issued slot
    logic [7:0]   top;  // highest issued slot
    logic [2:0]   ent;  // entry slot offered on the bus
    // helper decode, kept combinational so checks see the same cycle
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            chn[k] = issue_dat_o[EPD_WORD_W*k];
            keep[32*k +: 32] = {32{issue_msk_o[k]}};
        end
    end
    assign low = issue_msk_o & (~issue_msk_o + 8'h01);
    assign top = issue_msk_o & ~(issue_msk_o >> 1);
    assign ent = fetch_adr_i[EPD_SLOT_MSB:EPD_SLOT_LSB];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_take; fetch_vld_i && fetch_rdy_o |=> issue_vld_o; endproperty
    a_take: assert property (p_take) else $error("no group after take");
    property p_entry;
        fetch_vld_i && fetch_rdy_o |=> low == (8'h01 << $past(ent));
    endproperty
    a_entry: assert property (p_entry) else $error("bad entry slot");
    property p_span; issue_vld_o |-> low != 8'h00 && ((issue_msk_o + low) & issue_msk_o) == 0;
    endproperty
    a_span: assert property (p_span) else $error("group not contiguous");
    property p_inner; issue_vld_o |-> ((issue_msk_o & (issue_msk_o >> 1)) & ~chn) == 8'h00;
    endproperty
    a_inner: assert property (p_inner) else $error("unchained slot inside");
    property p_close; issue_vld_o |-> (top & chn & 8'h7f) == 8'h00; endproperty
    a_close: assert property (p_close) else $error("chained slot ends group");
    property p_next;
        issue_vld_o && !issue_lst_o |=> issue_vld_o && low == ($past(top) << 1);
    endproperty
    a_next: assert property (p_next) else $error("next group misplaced");
    property p_last; issue_vld_o |-> issue_lst_o == issue_msk_o[7]; endproperty
    a_last: assert property (p_last) else $error("last flag wrong");
    property p_hold; issue_vld_o && !issue_lst_o |-> !fetch_rdy_o; endproperty
    a_hold: assert property (p_hold) else $error("ready while groups remain");
    property p_zero; issue_vld_o |-> (issue_dat_o & ~keep) == '0; endproperty
    a_zero: assert property (p_zero) else $error("idle slot not zero");
    property p_sticky; align_err_o |=> align_err_o; endproperty
    a_sticky: assert property (p_sticky) else $error("align flag cleared");
    c_full: cover property (issue_vld_o && issue_msk_o == 8'hff);
    c_branch: cover property (fetch_vld_i && fetch_rdy_o && fetch_adr_i[4:2] != 3'h0);
    c_single: cover property (issue_vld_o && issue_msk_o == 8'h01);
endmodule // epd_dispatch_props
bind epd_dispatch epd_dispatch_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .fetch_vld_i(fetch_vld_i), .fetch_adr_i(fetch_adr_i), .fetch_dat_i(fetch_dat_i),
    .fetch_rdy_o(fetch_rdy_o), .issue_vld_o(issue_vld_o), .issue_msk_o(issue_msk_o),
    .issue_dat_o(issue_dat_o), .issue_lst_o(issue_lst_o), .align_err_o(align_err_o));

// >>> testbench/epd_fetch_model.sv
`timescale 1ns/10ps
// fetch stage stand-in: offers one group and holds it until taken
module epd_fetch_model
    import epd_pkg::*;
(
    input  wire logic                 clk_i,       // core clock
    input  wire logic                 fetch_rdy_i, // dispatch ready
    output logic                      fetch_vld_o, // group offered
    output logic [EPD_ADDR_W-1:0]     fetch_adr_o, // entry address
    output logic [EPD_SLOTS*32-1:0]   fetch_dat_o  // eight words
);
    initial begin
        fetch_vld_o = 1'b0;
        fetch_adr_o = '0;
        fetch_dat_o = '0;
    end
    // called just after an edge; ready is registered so it is settled here
    task automatic offer(input logic [31:0] a, input logic [255:0] d);
        fetch_vld_o = 1'b1;
        fetch_adr_o = a;
        fetch_dat_o = d;
        while (fetch_rdy_i !== 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
        fetch_vld_o = 1'b0;
        fetch_adr_o = ~a; // released bus shows junk, never the old group
        fetch_dat_o = ~d;
    endtask
endmodule // epd_fetch_model

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import epd_pkg::*;
    logic clk_i, reset_n_i, fetch_vld_i, fetch_rdy_o, issue_vld_o, issue_lst_o, align_err_o;
    logic [31:0]  fetch_adr_i;
    logic [255:0] fetch_dat_i, issue_dat_o;
    logic [7:0]   issue_msk_o;
    int num_errors = 0;
    int check_count = 0;
    epd_dispatch u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .fetch_vld_i(fetch_vld_i),
        .fetch_adr_i(fetch_adr_i), .fetch_dat_i(fetch_dat_i), .fetch_rdy_o(fetch_rdy_o),
        .issue_vld_o(issue_vld_o), .issue_msk_o(issue_msk_o), .issue_dat_o(issue_dat_o),
        .issue_lst_o(issue_lst_o), .align_err_o(align_err_o));
    epd_fetch_model u_src (.clk_i(clk_i), .fetch_rdy_i(fetch_rdy_o),
        .fetch_vld_o(fetch_vld_i), .fetch_adr_o(fetch_adr_i), .fetch_dat_o(fetch_dat_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one group: offer it, then judge every issue group in turn;
    // ex holds one expected mask per byte, lowest byte first, unused bytes zero
    task automatic run(input logic [7:0] ch, input logic [4:0] lo, input logic [63:0] ex);
        logic [255:0] d;
        logic [255:0] e;
        int w;
        int n;
        n = 0;
        for (int k = 0; k < 8; k++) d[32*k +: 32] = {8'(k), 8'h5a, 15'(k * 3), ch[k]};
        for (int g = 0; g < 8; g++) if (ex[8*g +: 8] != 8'h00) n++;
        fork
            u_src.offer({27'h40, lo}, d);
            begin
                for (int g = 0; g < n; g++) begin
                    w = 0;
                    while (issue_vld_o !== 1'b1 && w < 40) begin
                        @(posedge clk_i);
                        #1;
                        w++;
                    end
                    e = '0;
                    for (int k = 0; k < 8; k++) if (ex[8*g+k]) e[32*k +: 32] = d[32*k +: 32];
                    check(issue_vld_o, 1'b1);
                    check(issue_msk_o, ex[8*g +: 8]);
                    check(issue_dat_o, e);
                    check(issue_lst_o, g == n - 1);
                    check(fetch_rdy_o, g == n - 1);
                    @(posedge clk_i);
                    #1;
                end
            end
        join
        check(issue_vld_o, 1'b0);
    endtask
    task automatic t_partial;
        run(8'h6c, 5'h00, 64'he0_1c_02_01);
        $display("partial chain test done");
    endtask
    task automatic t_edges;
        run(8'h7f, 5'h00, 64'hff);
        run(8'h00, 5'h00, 64'h80_40_20_10_08_04_02_01);
        run(8'hff, 5'h00, 64'hff);
        $display("parallel, serial and overrun tests done");
    endtask
    task automatic t_branch;
        check(align_err_o, 1'b0);
        run(8'h6c, 5'h0c, 64'he0_18);
        run(8'h6c, 5'h1c, 64'h80);
        run(8'h6c, 5'h0d, 64'he0_18);
        check(align_err_o, 1'b1);
        $display("branch entry tests done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        end_of_test();
    end
    initial begin
        reset_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        t_edges();
        t_partial();
        t_branch();
        end_of_test();
    end
endmodule // tb_top
